// ==== rtl/lrc_light_regs.sv ====
// Light result and operating setup registers behind an APB slave
// What this block does
// - The result word at index zero holds the latest completed measurement.
// - The result word carries a 4-bit exponent in 15:12 and a 12-bit mantissa in 11:0.
// - The mantissa is unsigned straight binary from zero to full scale.
// - Both result fields are read-only and reset to zero.
// - Exponent codes 0 to 11 weigh an LSB at 0.01 lux times two to the exponent.
// - With the exponent mask set and a manual range below 1100b the exponent reads zero.
// - The setup word sits at index one and resets to C810h.
// - A host write to the setup word cancels a running measurement at once.
// - If the new setup calls for a measurement, a fresh conversion starts with it.
// - The setup word holds eleven fields in the fixed bit layout.
// - Setup bits 8 to 5 are read-only, all other setup bits are read and write.
// - Mode 00 is shutdown, 01 one conversion then back to 00, 10 and 11 continuous.
// - Range 1100b selects automatic range reported in the exponent; 1101b-1111b reserved.
// - Conversion time bit 0 gives 100 ms, 1 gives 800 ms.
`timescale 1ns/1ns
module lrc_light_regs
  import lrc_pkg::*;
#(
  parameter int SHORT_CYC = CONV_SHORT_CYC,
  parameter int LONG_CYC = CONV_LONG_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Light front end, same clock domain
  input wire logic [RES_MANT_W-1:0] fe_mantissa,
  input wire logic [3:0] fe_exponent,
  input wire logic fe_overflow,
  input wire logic fe_high_trip,
  input wire logic fe_low_trip,
  output logic fe_busy,
  output logic fe_long,
  output logic [3:0] fe_range,
  // Interrupt
  output logic irq
);

  logic [REG_W-1:0] result_reg;
  logic [REG_W-1:0] setup_reg;
  logic [REG_W-1:0] setup_next;
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [DATA_W-1:0] rd_word;
  logic [2:0] dec;
  logic setup_phase;
  logic xfer;
  logic setup_wr;
  logic mask_wr;
  logic rd_stat;
  logic rd_setup;
  logic conv_start;
  logic conv_done;
  logic conv_busy;
  logic [3:0] exp_sel;
  logic [1:0] mode;
  logic [1:0] wr_mode;
  logic [IRQ_W-1:0] stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] stat_clr;
  logic long_pick;
  logic [CNT_W-1:0] run_len;
  logic run_long;

  // One register match for every strobe, so none can skip the valid bit
  function automatic logic reg_hit(input logic [2:0] d, input logic [1:0] idx);
    reg_hit = d[2] && (d[1:0] == idx);
  endfunction

  // Bus phase decode
  assign dec = lrc_decode(paddr);
  assign setup_phase = psel && !penable;
  assign xfer = psel && penable && pready_reg;
  assign setup_wr = xfer && pwrite && reg_hit(dec, IDX_SETUP);
  assign mask_wr = xfer && pwrite && reg_hit(dec, IDX_MASK);
  assign rd_stat = xfer && !pwrite && reg_hit(dec, IDX_STAT);
  assign rd_setup = xfer && !pwrite && reg_hit(dec, IDX_SETUP);
  assign mode = setup_reg[CFG_MODE_LSB +: 2];
  assign wr_mode = pwdata[CFG_MODE_LSB +: 2];

  // Read mux; narrow registers sit in the low bits
  always_comb begin
    rd_word = '0;
    case (dec[1:0])
      IDX_RESULT: rd_word = {16'h0000, result_reg};
      IDX_SETUP: rd_word = {16'h0000, setup_reg};
      IDX_STAT: rd_word = {28'h0000000, stat};
      IDX_MASK: rd_word = {28'h0000000, irq_mask};
      default: rd_word = '0;
    endcase
    if (!dec[2]) begin
      rd_word = '0;
    end
  end

  // Zero-wait response: data captured in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !dec[2];
      prdata_reg <= setup_phase ? rd_word : 32'h00000000;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // Only bits the host actually saw are cleared, so late events survive
  assign stat_clr = rd_stat ? prdata_reg[IRQ_W-1:0] : 4'h0;

  // Completion events
  always_comb begin
    events = 4'h0;
    events[EV_DONE] = conv_done;
    events[EV_OVF] = conv_done && fe_overflow;
    events[EV_HIGH] = conv_done && fe_high_trip;
    events[EV_LOW] = conv_done && fe_low_trip;
  end

  // Time select follows a write in flight, else the stored bit
  assign long_pick = setup_wr ? pwdata[CFG_CT_BIT] : setup_reg[CFG_CT_BIT];

  // Write aborts; a non-shutdown mode re-arms at once
  assign conv_start = (setup_wr && (wr_mode != MODE_SHUTDOWN))
    || (conv_done && mode[1] && !setup_wr);

  lrc_conv_timer #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(conv_start),
    .abort(setup_wr),
    .long_sel(long_pick),
    .busy(conv_busy),
    .done(conv_done)
  );

  lrc_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_in(events),
    .clear_in(stat_clr),
    .mask_wr(mask_wr),
    .mask_wdata(pwdata[IRQ_W-1:0]),
    .status(stat),
    .mask(irq_mask),
    .irq(irq)
  );

  // Setup word next value: hardware flags, then host write on writable bits
  always_comb begin
    setup_next = setup_reg;
    if (rd_setup && prdata_reg[CFG_DONE_BIT]) begin
      setup_next[CFG_DONE_BIT] = 1'b0;
    end
    if (conv_done) begin
      setup_next[CFG_OVF_BIT] = fe_overflow;
      setup_next[CFG_DONE_BIT] = 1'b1;
      setup_next[CFG_HIGH_BIT] = fe_high_trip;
      setup_next[CFG_LOW_BIT] = fe_low_trip;
      if (mode == MODE_SINGLE) begin
        setup_next[CFG_MODE_LSB +: 2] = MODE_SHUTDOWN;
      end
    end
    if (setup_wr) begin
      setup_next = (pwdata[REG_W-1:0] & SETUP_WR_MASK) | (setup_next & ~SETUP_WR_MASK);
    end
  end

  // Setup register, fields per the fixed layout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_reg <= SETUP_RESET;
    end else begin
      setup_reg <= setup_next;
    end
  end

  // Exponent source: front end for auto and reserved ranges, else zero if masked, else the manual code
  always_comb begin
    exp_sel = setup_reg[CFG_RANGE_LSB +: 4];
    if (setup_reg[CFG_RANGE_LSB +: 4] >= RANGE_AUTO) begin
      exp_sel = fe_exponent;
    end else if (setup_reg[CFG_EXPMASK_BIT]) begin
      exp_sel = 4'h0;
    end
  end

  // Whole word written in one edge so a read never mixes results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= RESULT_RESET;
    end else if (conv_done) begin
      result_reg <= {exp_sel, fe_mantissa};
    end
  end

  // Front end steering
  assign fe_busy = conv_busy;
  assign fe_long = setup_reg[CFG_CT_BIT];
  assign fe_range = setup_reg[CFG_RANGE_LSB +: 4];

  // Check helper: busy cycles of the current run and its time select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len <= 24'h000000;
      run_long <= 1'b0;
    end else if (conv_start) begin
      run_len <= 24'h000000;
      run_long <= long_pick;
    end else if (conv_busy) begin
      run_len <= run_len + 24'h000001;
    end
  end

  a_result_atomic: assert property (@(posedge pclk) disable iff (!presetn)
    (result_reg != $past(result_reg)) |-> $past(conv_done)) else $error("result moved");

  a_result_fields: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> result_reg[RES_MANT_W-1:0] == $past(fe_mantissa))
    else $error("mantissa not taken");

  a_exp_masked: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && setup_reg[CFG_EXPMASK_BIT] && (setup_reg[15:12] < RANGE_AUTO)
    |=> result_reg[15:12] == 4'h0) else $error("exponent not masked");

  a_exp_auto: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && (setup_reg[15:12] == RANGE_AUTO)
    |=> result_reg[15:12] == $past(fe_exponent)) else $error("auto exponent lost");

  a_ro_bits: assert property (@(posedge pclk) disable iff (!presetn)
    setup_wr && !conv_done |=> setup_reg[8:5] == $past(setup_reg[8:5]))
    else $error("read-only setup bits written");

  a_rw_bits: assert property (@(posedge pclk) disable iff (!presetn)
    setup_wr |=> (setup_reg & SETUP_WR_MASK) == ($past(pwdata[15:0]) & SETUP_WR_MASK))
    else $error("setup write lost");

  a_abort_restart: assert property (@(posedge pclk) disable iff (!presetn)
    setup_wr && (wr_mode != MODE_SHUTDOWN) |=> conv_busy && !conv_done)
    else $error("no restart after write");

  a_abort_stop: assert property (@(posedge pclk) disable iff (!presetn)
    setup_wr && (wr_mode == MODE_SHUTDOWN) |=> !conv_busy [*2])
    else $error("abort failed");

  a_single_end: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && (mode == MODE_SINGLE) && !setup_wr
    |=> (mode == MODE_SHUTDOWN) && !conv_busy) else $error("single shot not ended");

  a_cont_rerun: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && mode[1] && !setup_wr |=> conv_busy) else $error("continuous stopped");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready ##1 !pready) else $error("apb answer timing");

  // Read paths and host write protection
  a_result_ro: assert property (@(posedge pclk) disable iff (!presetn)
    xfer && pwrite && reg_hit(dec, IDX_RESULT) && !conv_done |=> $stable(result_reg))
    else $error("result written by host");

  a_result_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && reg_hit(dec, IDX_RESULT) |=> prdata == {16'h0000, $past(result_reg)})
    else $error("result read wrong");

  a_setup_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && reg_hit(dec, IDX_SETUP) |=> prdata == {16'h0000, $past(setup_reg)})
    else $error("setup read wrong");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !dec[2] |=> pslverr && (prdata == 32'h00000000))
    else $error("unmapped access not refused");

  a_ready_err: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  // Exponent selection and setup flags at completion
  a_exp_manual: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && !setup_reg[CFG_EXPMASK_BIT] && (setup_reg[15:12] < RANGE_AUTO)
    |=> result_reg[15:12] == $past(setup_reg[15:12])) else $error("manual exponent wrong");

  a_exp_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && (setup_reg[15:12] > RANGE_AUTO)
    |=> result_reg[15:12] == $past(fe_exponent)) else $error("reserved range exponent");

  a_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> setup_reg[CFG_DONE_BIT])
    else $error("done flag not set");

  a_flags_load: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> (setup_reg[CFG_OVF_BIT] == $past(fe_overflow))
    && (setup_reg[CFG_HIGH_BIT] == $past(fe_high_trip))
    && (setup_reg[CFG_LOW_BIT] == $past(fe_low_trip))) else $error("flags not loaded");

  a_ro_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !conv_done && !rd_setup |=> $stable(setup_reg[8:5]))
    else $error("read-only bits moved");

  // Conversion sequencing
  a_conv_time: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |-> run_len == (run_long ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC)))
    else $error("conversion length wrong");

  a_abort_now: assert property (@(posedge pclk) disable iff (!presetn)
    setup_wr |=> !conv_done)
    else $error("aborted run completed");

  a_mode_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_SINGLE) && !conv_done && !setup_wr |=> mode == MODE_SINGLE)
    else $error("single mode left early");

  a_shutdown_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_SHUTDOWN) && !conv_busy && !setup_wr |=> !conv_busy)
    else $error("conversion in shutdown");

  c_single_done: cover property (@(posedge pclk) disable iff (!presetn)
    conv_done && (mode == MODE_SINGLE));
  c_write_abort: cover property (@(posedge pclk) disable iff (!presetn)
    setup_wr && conv_busy);
  c_irq_fire: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_cont_restart: cover property (@(posedge pclk) disable iff (!presetn)
    conv_done && mode[1]);

endmodule // lrc_light_regs

// ==== rtl/lrc_pkg.sv ====
// Shared constants, field layout and address decode for the light result block
package lrc_pkg;

  // Bus and register widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [1:0] IDX_RESULT = 2'h0;
  localparam logic [1:0] IDX_SETUP = 2'h1;
  localparam logic [1:0] IDX_STAT = 2'h2;
  localparam logic [1:0] IDX_MASK = 2'h3;

  // Result word fields
  localparam int RES_EXP_LSB = 12;
  localparam int RES_MANT_W = 12;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Setup word fields
  localparam int CFG_RANGE_LSB = 12;
  localparam int CFG_CT_BIT = 11;
  localparam int CFG_MODE_LSB = 9;
  localparam int CFG_OVF_BIT = 8;
  localparam int CFG_DONE_BIT = 7;
  localparam int CFG_HIGH_BIT = 6;
  localparam int CFG_LOW_BIT = 5;
  localparam int CFG_EXPMASK_BIT = 2;
  localparam logic [15:0] SETUP_RESET = 16'hC810;
  localparam logic [15:0] SETUP_WR_MASK = 16'hFE1F;

  // Range and mode codes
  localparam logic [3:0] RANGE_AUTO = 4'hC;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;

  // Interrupt status / mask layout
  localparam int IRQ_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_OVF = 1;
  localparam int EV_HIGH = 2;
  localparam int EV_LOW = 3;
  localparam logic [3:0] STAT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // Conversion timing
  localparam longint CLK_HZ = 64'd20_000_000;
  localparam longint MS_PER_S = 64'd1000;
  localparam longint CONV_SHORT_MS = 64'd100;
  localparam longint CONV_LONG_MS = 64'd800;
  localparam int CONV_SHORT_CYC = int'((CONV_SHORT_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S);
  localparam int CONV_LONG_CYC = int'((CONV_LONG_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S);
  localparam int CNT_W = 24;

  // Address decode: {valid, index}
  function automatic logic [2:0] lrc_decode(input logic [ADDR_W-1:0] addr);
    lrc_decode = {(addr[1:0] == 2'h0) && (addr[7:4] == 4'h0), addr[3:2]};
  endfunction

endpackage

// ==== rtl/lrc_conv_timer.sv ====
// Conversion interval timer: start, abort, one-cycle done pulse
`timescale 1ns/1ns
module lrc_conv_timer
  import lrc_pkg::*;
#(
  parameter int SHORT_CYC = CONV_SHORT_CYC,
  parameter int LONG_CYC = CONV_LONG_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic long_sel,
  // Status
  output logic busy,
  output logic done
);

  logic [CNT_W-1:0] cnt_reg;

  // Start wins over abort so a write that re-arms restarts cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 24'h000000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
        busy <= 1'b1;
      end else if (abort) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (cnt_reg == 24'h000000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 24'h000001;
        end
      end
    end
  end

  // Done never fires without a running conversion
  a_done_busy: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> $past(busy) && !busy) else $error("done without busy");

endmodule // lrc_conv_timer

// ==== rtl/lrc_irq.sv ====
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ns
module lrc_irq
  import lrc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Events and clears
  input wire logic [IRQ_W-1:0] event_in,
  input wire logic [IRQ_W-1:0] clear_in,
  // Mask write
  input wire logic mask_wr,
  input wire logic [IRQ_W-1:0] mask_wdata,
  // State
  output logic [IRQ_W-1:0] status,
  output logic [IRQ_W-1:0] mask,
  output logic irq
);

  // Set wins over the read clear of the same bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STAT_RESET;
    end else begin
      status <= (status & ~clear_in) | event_in;
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= MASK_RESET;
    end else if (mask_wr) begin
      mask <= mask_wdata;
    end
  end

  // Registered level output; lags status by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(status) & $past(mask))) else $error("irq level wrong");

endmodule // lrc_irq

// ==== test/lrc_fe_model.sv ====
// Light front end stand-in answering the register block's conversions
`timescale 1ns/1ns
module lrc_fe_model (
  // Clock of the block
  input wire logic pclk,
  // Conversion running
  input wire logic fe_busy,
  // Values the bench wants measured
  input wire logic [11:0] set_mant,
  input wire logic [3:0] set_exp,
  input wire logic [2:0] set_flags,
  // Results towards the block
  output logic [11:0] fe_mantissa,
  output logic [3:0] fe_exponent,
  output logic fe_overflow,
  output logic fe_high_trip,
  output logic fe_low_trip
);
  logic busy_d = 1'b0;
  logic valid;

  // Busy one edge late: the block takes results on the edge after busy falls
  always @(posedge pclk) busy_d <= fe_busy;
  assign valid = fe_busy || busy_d;

  // Outside that window outputs flip, so a sample taken at the wrong edge reads wrong
  assign fe_mantissa = valid ? set_mant : ~set_mant;
  assign fe_exponent = valid ? set_exp : ~set_exp;
  assign {fe_overflow, fe_high_trip, fe_low_trip} = valid ? set_flags : ~set_flags;
endmodule // lrc_fe_model

// ==== test/testbench.sv ====
// Self-checking bench for the light result and setup register block
`timescale 1ns/1ns
module testbench;
  import lrc_pkg::*;
  localparam int N_S = 5;
  localparam int N_L = 12;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, fe_overflow, fe_high_trip, fe_low_trip, fe_busy, fe_long, irq;
  logic [11:0] fe_mantissa;
  logic [11:0] set_mant = 12'h000;
  logic [3:0] fe_exponent, fe_range;
  logic [3:0] set_exp = 4'h0;
  logic [2:0] set_flags = 3'h0;
  int fails = 0;
  int n_compared = 0;
  int busy_cnt = 0;
  int c0;
  logic [31:0] rd;
  logic er;

  // 20 MHz clock
  always #25 pclk = ~pclk;

  // Cycles spent converting, for timing checks
  always @(posedge pclk) begin
    if (fe_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  lrc_light_regs #(.SHORT_CYC(N_S), .LONG_CYC(N_L)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fe_mantissa(fe_mantissa), .fe_exponent(fe_exponent), .fe_overflow(fe_overflow),
    .fe_high_trip(fe_high_trip), .fe_low_trip(fe_low_trip), .fe_busy(fe_busy),
    .fe_long(fe_long), .fe_range(fe_range), .irq(irq));

  lrc_fe_model fe (
    .pclk(pclk),
    .fe_busy(fe_busy), .set_mant(set_mant), .set_exp(set_exp), .set_flags(set_flags),
    .fe_mantissa(fe_mantissa), .fe_exponent(fe_exponent), .fe_overflow(fe_overflow),
    .fe_high_trip(fe_high_trip), .fe_low_trip(fe_low_trip));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; an edge passes first so strobes never toggle twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  // Bounded wait for the running conversion to end
  task automatic wait_conv();
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (fe_busy !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) begin
      fails++;
      summarize();
    end
  endtask

  task automatic t_reset();
    rdc("result", 8'h00, 32'h0);
    rdc("setup", 8'h04, 32'h0000C810);
    chk("range out", {27'h0, fe_long, fe_range}, 32'h1C);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
  endtask

  task automatic t_access();
    apb(1'b1, 8'h04, 32'h0000F9FF);
    rdc("setup rw", 8'h04, 32'h0000F81F);
    chk("range out", {27'h0, fe_long, fe_range}, 32'h1F);
    apb(1'b1, 8'h00, 32'h0000FFFF);
    rdc("result ro", 8'h00, 32'h0);
  endtask

  // Single shot, auto range, then interrupt masked, raised and cleared
  task automatic t_single();
    set_mant <= 12'hABC;
    set_exp <= 4'h7;
    c0 = busy_cnt;
    apb(1'b1, 8'h04, 32'h0000C200);
    rdc("mode running", 8'h04, 32'h0000C200);
    wait_conv();
    chk("short time", 32'(busy_cnt - c0), N_S);
    rdc("result", 8'h00, 32'h00007ABC);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, 8'h0C, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rdc("setup done", 8'h04, 32'h0000C080);
    rdc("status", 8'h08, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  // Manual range with and without exponent mask, long time, flags
  task automatic t_manual();
    set_mant <= 12'h456;
    set_exp <= 4'h9;
    set_flags <= 3'h7;
    c0 = busy_cnt;
    apb(1'b1, 8'h04, 32'h00003A04);
    wait_conv();
    chk("long time", 32'(busy_cnt - c0), N_L);
    rdc("masked exp", 8'h00, 32'h00000456);
    apb(1'b1, 8'h04, 32'h00003200);
    wait_conv();
    rdc("manual exp", 8'h00, 32'h00003456);
    rdc("flags", 8'h04, 32'h000031E0);
    rdc("status flags", 8'h08, 32'h0000000F);
  endtask

  // Continuous modes, abort and restart by setup writes
  task automatic t_abort();
    set_mant <= 12'h111;
    set_exp <= 4'h2;
    set_flags <= 3'h0;
    apb(1'b1, 8'h04, 32'h0000C600);
    repeat (N_S + 3) @(posedge pclk);
    chk("mode 11 runs", {31'h0, fe_busy}, 32'h1);
    apb(1'b1, 8'h04, 32'h0000C400);
    repeat (N_S + 3) @(posedge pclk);
    chk("mode 10 runs", {31'h0, fe_busy}, 32'h1);
    apb(1'b1, 8'h04, 32'h0000C000);
    wait_conv();
    rdc("continuous", 8'h00, 32'h00002111);
    set_mant <= 12'h333;
    c0 = busy_cnt;
    apb(1'b1, 8'h04, 32'h0000C200);
    apb(1'b1, 8'h04, 32'h0000C000);
    wait_conv();
    chk("aborted early", {31'h0, 32'(busy_cnt - c0) < N_S}, 32'h1);
    rdc("result kept", 8'h00, 32'h00002111);
    set_mant <= 12'h444;
    set_exp <= 4'h5;
    c0 = busy_cnt;
    apb(1'b1, 8'h04, 32'h0000C200);
    apb(1'b1, 8'h04, 32'h0000C200);
    wait_conv();
    chk("restarted", {31'h0, 32'(busy_cnt - c0) > N_S}, 32'h1);
    rdc("fresh result", 8'h00, 32'h00005444);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_access();
    t_single();
    t_manual();
    t_abort();
    summarize();
  end
endmodule // testbench
